// File: src/mad_consts.svh
// Purpose: constants for the modem autodial sequencer
// Assumes: 100 MHz clock, 32-bit classic Wishbone register bus
// Notes:   byte addresses, field positions, codes and timing counts
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH

// register byte addresses
`define MAD_ADR_CTRL      12'h000
`define MAD_ADR_CMD       12'h004
`define MAD_ADR_TMO       12'h008
`define MAD_ADR_LEN       12'h00c
`define MAD_ADR_STATUS    12'h010
`define MAD_ADR_IRQ_STAT  12'h014
`define MAD_ADR_IRQ_MASK  12'h018
`define MAD_ADR_RSP       12'h01c
`define MAD_ADR_STR_BASE  12'h200
`define MAD_STR_WORDS     125

// control and status fields
`define MAD_CTRL_START    0
`define MAD_CTRL_MASTER   1
`define MAD_ST_BUSY       0
`define MAD_ST_DONE       1
`define MAD_ST_ERR_LSB    4
`define MAD_IRQ_DONE      0
`define MAD_IRQ_ERR       1

// command and string
`define MAD_CMD_DIAL      16'h1ce8
`define MAD_LEN_MIN       16'h0001
`define MAD_LEN_MAX       16'h00fa
`define MAD_CHR_PLUS      8'h2b
`define MAD_CHR_CR        8'h0d
`define MAD_CHR_LF        8'h0a
`define MAD_CHR_ECHO      8'h41
`define MAD_CHR_OK        8'h4f
`define MAD_CHR_CONNECT   8'h43
`define MAD_PLUS_COUNT    12'h003

// error codes
`define MAD_ERR_NONE      4'h0
`define MAD_ERR_CMD       4'h1
`define MAD_ERR_MODE      4'h2
`define MAD_ERR_LEN       4'h3
`define MAD_ERR_TMO       4'h4
`define MAD_ERR_RSP       4'h5

// timing
`define MAD_CLK_HZ        100000000
`define MAD_SIL_S         2
`define MAD_MS_PER_S      1000
`define MAD_CYC_PER_MS    (`MAD_CLK_HZ / `MAD_MS_PER_S)
`define MAD_SIL_MS        (`MAD_SIL_S * `MAD_MS_PER_S)

`endif

// File: src/mad_pkg.sv
// Purpose: types of the modem autodial sequencer
// Assumes: constants come from mad_consts.svh
// Notes:   the whole sequencer state is one packed struct
package mad_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SIL1, ST_PLUS, ST_SIL2, ST_FETCH, ST_LOAD, ST_SEND, ST_RESP
  } mad_phase_t;

  typedef struct packed {
    mad_phase_t  st;
    logic        master;
    logic [15:0] cmd_num;
    logic [15:0] tmo;
    logic [15:0] len;
    logic [3:0]  err;
    logic        done;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        ack;
    logic [31:0] rdat;
    logic [11:0] cnt;
    logic [9:0]  ms_in_s;
    logic [15:0] secs;
    logic [7:0]  idx;
    logic [7:0]  tx_byte;
    logic [7:0]  rsp_first;
    logic [7:0]  rsp_last;
    logic        rsp_any;
  } mad_state_t;

endpackage

// File: src/mad_tick_div.sv
// Purpose: divider giving a one-cycle enable pulse every DIV clocks
// Assumes: one clock; en_i low holds the divider at zero
// Notes:   restarting on en_i keeps the first tick a full period away
`timescale 1ns/1ps
`default_nettype none
module mad_tick_div #(
  parameter int DIV = 100000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      tick_o
);
  logic [16:0] cnt_q;

  // count up to DIV-1 then wrap with a pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_q <= 17'h00000;
    end else if (cnt_q == 17'(DIV - 1)) begin
      cnt_q <= 17'h00000;
    end else begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end

  assign tick_o = en_i && (cnt_q == 17'(DIV - 1));
endmodule
`default_nettype wire

// File: src/mad_str_mem.sv
// Purpose: command string store, 128 words of two characters
// Assumes: one write port from the bus, one read port for the sender
// Notes:   read data is registered, so it follows the address by one cycle
`timescale 1ns/1ps
`default_nettype none
module mad_str_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [6:0]  waddr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [6:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem_q [128];

  // byte-lane writes, registered read
  always_ff @(posedge clk_i) begin
    if (we_i && be_i[0]) begin
      mem_q[waddr_i][7:0] <= wdata_i[7:0];
    end
    if (we_i && be_i[1]) begin
      mem_q[waddr_i][15:8] <= wdata_i[15:8];
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

// File: src/mad_sequencer.sv
// Purpose: dial-out command sequencer for a serial port towards a modem
// Assumes: byte UART on the same clock with valid/ready transmit side
// Notes:   registers over classic Wishbone, one level interrupt
// Functional notes
// R1: only command number 1ce8 hex is run, and only with the port as master.
// R2: the operation is local, bytes go to the modem and no link message.
// R3: a start sends 2 s silence, three plus characters, then 2 s silence.
// R4: the command string follows the trailing silence with no added gap.
// R5: software ends every string with a carriage return inside the data.
// R6: software sets block length to (byte count + 1) / 2 + 3.
// R7: the byte count is 1 to 250 and exactly that many bytes are sent.
// R8: timeout seconds, byte count and the string words form the block.
// R9: a zero timeout completes right after the last string byte.
// R10: a nonzero timeout waits that many seconds for the reply, else error.
// R11: software hangs up by reissuing the command with a hang-up string.
// R12: each word gives two characters, low byte first, stopping at count.
//
// Register access over Wishbone and the register addresses were decided locally.
`include "mad_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mad_sequencer #(
  parameter int CYC_PER_MS = `MAD_CYC_PER_MS,
  parameter int SIL_MS     = `MAD_SIL_MS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  output logic             busy_o,
  output logic             irq_o
);
  mad_pkg::mad_state_t s_q;
  mad_pkg::mad_state_t s_d;
  logic                ms_tick;
  logic [15:0]         mem_rdata;
  logic                bus_req;
  logic                bus_wr;
  logic                str_we;
  logic [6:0]          str_waddr;

  // string window decode, used by the write strobe only
  function automatic logic in_str(input logic [11:0] adr);
    logic [11:0] off;
    off = adr - `MAD_ADR_STR_BASE;
    return (adr >= `MAD_ADR_STR_BASE) &&
           (off[11:2] < 10'(`MAD_STR_WORDS));
  endfunction

  // merge a 16-bit register with the two low byte lanes
  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[15:8] = dat[15:8];
    return r;
  endfunction

  // start strobe as seen by the checks
  function automatic logic start_w();
    return bus_wr && wb_adr_i == `MAD_ADR_CTRL && wb_sel_i[0] &&
           wb_dat_i[`MAD_CTRL_START];
  endfunction

  mad_tick_div #(
    .DIV (CYC_PER_MS)
  ) u_ms (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (s_q.st == mad_pkg::ST_SIL1 ||        // full period per wait
             s_q.st == mad_pkg::ST_SIL2 ||
             s_q.st == mad_pkg::ST_RESP),         // [R3] [R10]
    .tick_o (ms_tick)
  );

  // string words are written straight from the bus
  assign bus_req   = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign bus_wr    = bus_req && wb_we_i;
  assign str_we    = bus_wr && in_str(wb_adr_i);
  assign str_waddr = 7'((wb_adr_i - `MAD_ADR_STR_BASE) >> 2);

  mad_str_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (str_we),
    .be_i    (wb_sel_i[1:0]),
    .waddr_i (str_waddr),
    .wdata_i (wb_dat_i[15:0]),
    .raddr_i (s_q.idx[7:1]),                  // two bytes per word [R12]
    .rdata_o (mem_rdata)
  );

  // next-state logic: bus slave, sequencer, interrupt status
  always_comb begin
    logic       start;
    logic       fin_ok;
    logic       fin_err;
    logic [3:0] err_code;
    start    = 1'b0;
    fin_ok   = 1'b0;
    fin_err  = 1'b0;
    err_code = `MAD_ERR_NONE;
    s_d      = s_q;
    s_d.ack  = bus_req;

    // register writes; master, command, timeout and length are locked while a command runs
    if (bus_wr) begin
      case (wb_adr_i)
        `MAD_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            start = wb_dat_i[`MAD_CTRL_START];
            if (s_q.st == mad_pkg::ST_IDLE) begin
              s_d.master = wb_dat_i[`MAD_CTRL_MASTER];
            end
          end
        end
        `MAD_ADR_CMD: begin
          if (s_q.st == mad_pkg::ST_IDLE) begin
            s_d.cmd_num = lanes(s_q.cmd_num, wb_dat_i, wb_sel_i);
          end
        end
        `MAD_ADR_TMO: begin
          if (s_q.st == mad_pkg::ST_IDLE) begin
            s_d.tmo = lanes(s_q.tmo, wb_dat_i, wb_sel_i);   // [R8]
          end
        end
        `MAD_ADR_LEN: begin
          if (s_q.st == mad_pkg::ST_IDLE) begin
            s_d.len = lanes(s_q.len, wb_dat_i, wb_sel_i);   // [R8]
          end
        end
        `MAD_ADR_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            s_d.irq_mask = wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // register reads; string window is write only, holes read zero
    s_d.rdat = 32'h00000000;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `MAD_ADR_CTRL:     s_d.rdat = {30'h0, s_q.master, 1'b0};
        `MAD_ADR_CMD:      s_d.rdat = {16'h0000, s_q.cmd_num};
        `MAD_ADR_TMO:      s_d.rdat = {16'h0000, s_q.tmo};
        `MAD_ADR_LEN:      s_d.rdat = {16'h0000, s_q.len};
        `MAD_ADR_STATUS:   s_d.rdat = {24'h0, s_q.err, 2'b00, s_q.done,
                                       s_q.st != mad_pkg::ST_IDLE};
        `MAD_ADR_IRQ_STAT: s_d.rdat = {30'h0, s_q.irq_stat};
        `MAD_ADR_IRQ_MASK: s_d.rdat = {30'h0, s_q.irq_mask};
        `MAD_ADR_RSP:      s_d.rdat = {16'h0000, s_q.rsp_last, s_q.rsp_first};
        default:           s_d.rdat = 32'h00000000;
      endcase
    end

    // sequencer; a start while busy is ignored
    case (s_q.st)
      mad_pkg::ST_IDLE: begin
        if (start) begin
          if (s_q.cmd_num != `MAD_CMD_DIAL) begin           // [R1]
            fin_err  = 1'b1;
            err_code = `MAD_ERR_CMD;
          end else if (!s_q.master) begin                   // [R1]
            fin_err  = 1'b1;
            err_code = `MAD_ERR_MODE;
          end else if (s_q.len < `MAD_LEN_MIN ||
                       s_q.len > `MAD_LEN_MAX) begin        // [R7]
            fin_err  = 1'b1;
            err_code = `MAD_ERR_LEN;
          end else begin
            s_d.st      = mad_pkg::ST_SIL1;                 // [R3]
            s_d.cnt     = 12'h000;
            s_d.done    = 1'b0;
            s_d.err     = `MAD_ERR_NONE;
            s_d.rsp_any = 1'b0;
          end
        end
      end
      mad_pkg::ST_SIL1: begin
        // leading guard time, line left idle
        if (ms_tick) begin
          s_d.cnt = s_q.cnt + 12'h001;
          if (s_q.cnt == 12'(SIL_MS - 1)) begin
            s_d.st      = mad_pkg::ST_PLUS;                 // [R3]
            s_d.cnt     = 12'h000;
            s_d.tx_byte = `MAD_CHR_PLUS;
          end
        end
      end
      mad_pkg::ST_PLUS: begin
        if (tx_ready_i) begin
          s_d.cnt = s_q.cnt + 12'h001;
          if (s_q.cnt == `MAD_PLUS_COUNT - 12'h001) begin   // [R3]
            s_d.st  = mad_pkg::ST_SIL2;
            s_d.cnt = 12'h000;
          end
        end
      end
      mad_pkg::ST_SIL2: begin
        if (ms_tick) begin
          s_d.cnt = s_q.cnt + 12'h001;
          if (s_q.cnt == 12'(SIL_MS - 1)) begin
            s_d.st  = mad_pkg::ST_FETCH;                    // [R4]
            s_d.idx = 8'h00;
          end
        end
      end
      mad_pkg::ST_FETCH: begin
        // memory address settles this cycle, data is registered next
        s_d.st = mad_pkg::ST_LOAD;
      end
      mad_pkg::ST_LOAD: begin
        s_d.tx_byte = s_q.idx[0] ? mem_rdata[15:8]
                                 : mem_rdata[7:0];          // [R12]
        s_d.st      = mad_pkg::ST_SEND;
      end
      mad_pkg::ST_SEND: begin
        if (tx_ready_i) begin
          s_d.idx = s_q.idx + 8'h01;
          if ({8'h00, s_q.idx} == s_q.len - 16'h0001) begin // [R7]
            if (s_q.tmo == 16'h0000) begin
              fin_ok = 1'b1;                                // [R9]
            end else begin
              s_d.st      = mad_pkg::ST_RESP;               // [R10]
              s_d.ms_in_s = 10'h000;
              s_d.secs    = 16'h0000;
            end
          end else if (s_q.idx[0]) begin
            s_d.st = mad_pkg::ST_FETCH;                     // next word
          end else begin
            s_d.tx_byte = mem_rdata[15:8];                  // [R12]
          end
        end
      end
      mad_pkg::ST_RESP: begin
        // seconds counted from the ms tick
        if (ms_tick) begin
          s_d.ms_in_s = s_q.ms_in_s + 10'h001;
          if (s_q.ms_in_s == 10'(`MAD_MS_PER_S - 1)) begin
            s_d.ms_in_s = 10'h000;
            s_d.secs    = s_q.secs + 16'h0001;
            if (s_q.secs + 16'h0001 == s_q.tmo) begin       // [R10]
              fin_err  = 1'b1;
              err_code = `MAD_ERR_TMO;
            end
          end
        end
        // a reply line ends in CR; echoed command lines are skipped
        if (rx_valid_i && !fin_err) begin
          if (rx_data_i == `MAD_CHR_CR) begin
            if (s_q.rsp_any && s_q.rsp_first != `MAD_CHR_ECHO) begin
              if (s_q.rsp_first == `MAD_CHR_OK ||
                  s_q.rsp_first == `MAD_CHR_CONNECT) begin
                fin_ok = 1'b1;                              // [R10]
              end else begin
                fin_err  = 1'b1;
                err_code = `MAD_ERR_RSP;
              end
            end
            s_d.rsp_any = 1'b0;
          end else if (rx_data_i != `MAD_CHR_LF) begin
            if (!s_q.rsp_any) begin
              s_d.rsp_first = rx_data_i;
            end
            s_d.rsp_last = rx_data_i;
            s_d.rsp_any  = 1'b1;
          end
        end
      end
      default: begin
        s_d.st = mad_pkg::ST_IDLE;
      end
    endcase

    // completion; the port is left dialled, hang-up is software's job
    if (fin_ok || fin_err) begin
      s_d.st   = mad_pkg::ST_IDLE;
      s_d.done = 1'b1;
      s_d.err  = err_code;
    end

    // read clears status, a same-cycle event still lands
    if (bus_req && !wb_we_i && wb_adr_i == `MAD_ADR_IRQ_STAT) begin
      s_d.irq_stat = 2'b00;
    end
    if (fin_ok || fin_err) begin
      s_d.irq_stat[`MAD_IRQ_DONE] = 1'b1;
    end
    if (fin_err) begin
      s_d.irq_stat[`MAD_IRQ_ERR] = 1'b1;
    end
  end

  // one register for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.st       <= mad_pkg::ST_IDLE;
      s_q.tx_byte  <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; transmit only to the local modem, never a link frame
  assign wb_ack_o   = s_q.ack;
  assign wb_dat_o   = s_q.rdat;
  assign tx_data_o  = s_q.tx_byte;
  assign tx_valid_o = (s_q.st == mad_pkg::ST_PLUS) ||
                      (s_q.st == mad_pkg::ST_SEND);        // [R2]
  assign busy_o     = s_q.st != mad_pkg::ST_IDLE;
  assign irq_o      = |(s_q.irq_stat & s_q.irq_mask);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  bad_cmd_a: assert property ( // [R1]
    (s_q.st == mad_pkg::ST_IDLE && start_w() &&
     s_q.cmd_num != `MAD_CMD_DIAL)
    |=> s_q.st == mad_pkg::ST_IDLE && s_q.err == `MAD_ERR_CMD)
    else $error("wrong command number not refused");
  not_master_a: assert property ( // [R1]
    (s_q.st == mad_pkg::ST_IDLE && start_w() && !s_q.master)
    |=> s_q.st == mad_pkg::ST_IDLE && s_q.err != `MAD_ERR_NONE)
    else $error("command run without master mode");
  silent_line_a: assert property ( // [R2]
    tx_valid_o |-> s_q.master && s_q.cmd_num == `MAD_CMD_DIAL)
    else $error("byte offered outside a local dial command");
  plus_char_a: assert property ( // [R3]
    (s_q.st == mad_pkg::ST_PLUS && tx_valid_o) |-> tx_data_o == 8'h2b)
    else $error("escape byte is not plus");
  no_gap_a: assert property ( // [R4]
    (s_q.st == mad_pkg::ST_SIL2 && ms_tick &&
     s_q.cnt == 12'(SIL_MS - 1))
    |=> s_q.st == mad_pkg::ST_FETCH ##2 tx_valid_o)
    else $error("string does not follow silence");
  count_bound_a: assert property ( // [R7]
    s_q.st == mad_pkg::ST_SEND |-> {8'h00, s_q.idx} < s_q.len)
    else $error("byte sent beyond count");
  zero_tmo_a: assert property ( // [R9]
    (s_q.st == mad_pkg::ST_SEND && tx_ready_i && s_q.tmo == 16'h0000 &&
     {8'h00, s_q.idx} == s_q.len - 16'h0001)
    |=> s_q.done && !busy_o && s_q.err == `MAD_ERR_NONE)
    else $error("zero timeout did not complete");
  tmo_err_a: assert property ( // [R10]
    (s_q.st == mad_pkg::ST_RESP && ms_tick &&
     s_q.ms_in_s == 10'(`MAD_MS_PER_S - 1) &&
     s_q.secs + 16'h0001 == s_q.tmo)
    |=> s_q.err == `MAD_ERR_TMO && !busy_o)
    else $error("timeout did not report error");
  low_first_a: assert property ( // [R12]
    s_q.st == mad_pkg::ST_LOAD
    |-> !s_q.idx[0] ##1 tx_data_o == $past(mem_rdata[7:0]))
    else $error("word does not start with its low byte");

  dial_no_wait_c: cover property (s_q.st == mad_pkg::ST_SEND ##1
                                  (s_q.done && s_q.err == 4'h0));
  reply_ok_c:     cover property (s_q.st == mad_pkg::ST_RESP ##1
                                  (s_q.done && s_q.err == 4'h0));
  reply_tmo_c:    cover property (s_q.err == `MAD_ERR_TMO);
  irq_raised_c:   cover property (irq_o);
endmodule
`default_nettype wire

// File: dv/mad_modem_model.sv
// Purpose: behavioural modem on the byte link of the sequencer
// Assumes: same clock as the sequencer, one byte per valid/ready edge
// Notes:   reply 1 answers OK, 2 answers ERR, 0 stays silent
`timescale 1ns/1ps
`default_nettype none
module mad_modem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       slow_i,
  input  wire logic [1:0] reply_i
);
  logic [7:0] got[$];
  int         when[$];
  logic [7:0] out[$];
  int         cyc;
  int         gap;
  initial begin
    tx_ready_o = 1'b1;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    cyc = 0;
    gap = 0;
  end
  // take bytes, queue a reply once the command line ends
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
      when.push_back(cyc);
      if (tx_data_i == 8'h0d && reply_i == 2'h1) begin
        out = {8'h0d, 8'h0a, 8'h4f, 8'h4b, 8'h0d, 8'h0a};
        gap = 20;
      end
      if (tx_data_i == 8'h0d && reply_i == 2'h2) begin
        out = {8'h0d, 8'h0a, 8'h45, 8'h52, 8'h52, 8'h0d, 8'h0a};
        gap = 20;
      end
    end
    if (rst_i) begin
      out.delete();
    end
    // idle data toggles so a stale byte is never mistaken for a fresh one
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    if (gap > 0) begin
      gap = gap - 1;
    end else if (out.size() > 0) begin
      rx_data_o <= out.pop_front();
      rx_valid_o <= 1'b1;
      gap = 3;
    end
    tx_ready_o <= slow_i ? 1'($urandom_range(1, 0)) : 1'b1;
  end
endmodule
`default_nettype wire

// File: dv/tb_modem_autodial_sequencer.sv
// Purpose: self-checking bench for the modem autodial sequencer
// Assumes: shortened timing, modem model on the byte link
// Notes:   expected bytes come from a queue model rebuilt per run
`include "mad_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_modem_autodial_sequencer;
  localparam int CPM = 2;
  localparam int SIL = CPM * 3;
  logic        clk_i;
  logic        rst_i;
  logic [11:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        we;
  logic [3:0]  sel;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic [7:0]  txd;
  logic        txv;
  logic        txr;
  logic [7:0]  rxd;
  logic        rxv;
  logic        busy;
  logic        irq;
  logic        slow;
  logic [1:0]  reply;
  logic [31:0] q;
  logic [7:0]  exp[$];
  int          n_errors;
  int          check_count;

  mad_sequencer #(.CYC_PER_MS(CPM), .SIL_MS(3)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_ready_i(txr), .rx_data_i(rxd), .rx_valid_i(rxv), .busy_o(busy),
    .irq_o(irq));
  mad_modem_model modem_u (
    .clk_i(clk_i), .rst_i(rst_i), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .slow_i(slow),
    .reply_i(reply));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    close_out();
  endtask

  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    while (n < 20) begin
      @(posedge clk_i);
      n++;
      if (ack === 1'b1) begin
        break;
      end
    end
    if (ack !== 1'b1) begin
      hang();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // load a command, start it and compare against the queue model
  task automatic run(input string txt, input int len,
                     input logic [15:0] cmd, input logic mst,
                     input logic [15:0] tmo, input logic [1:0] rp,
                     input logic [1:0] msk, input logic [3:0] ee,
                     input logic slw);
    logic [7:0] s[$];
    int         t0;
    int         n;
    int         t1;
    int         blk;
    logic       sent;
    if (txt.len() > 0) begin
      len = txt.len();
    end
    for (int i = 0; i < len && i < 250; i++) begin
      s.push_back(i < txt.len() ? txt[i] : 8'h20 + 8'($urandom_range(94)));
    end
    if (txt.len() == 0 && s.size() > 0) begin
      s[s.size() - 1] = `MAD_CHR_CR;
    end
    slow <= slw;
    reply <= rp;
    wb(1'b1, `MAD_ADR_CTRL, {30'h0, mst, 1'b0});
    wb(1'b1, `MAD_ADR_CMD, {16'h0, cmd});
    wb(1'b1, `MAD_ADR_TMO, {16'h0, tmo});
    wb(1'b1, `MAD_ADR_LEN, 32'(len));
    wb(1'b1, `MAD_ADR_IRQ_MASK, {30'h0, msk});
    // pad byte of an odd string is random so a stray send shows up
    blk = (s.size() + 1) / 2 + 3; // block length word
    for (int w = 0; w < blk - 3; w++) begin
      wb(1'b1, `MAD_ADR_STR_BASE + 12'(4 * w), {16'h0,
         (2 * w + 1 < s.size()) ? s[2 * w + 1] : 8'($urandom), s[2 * w]});
    end
    modem_u.got.delete();
    modem_u.when.delete();
    exp = {`MAD_CHR_PLUS, `MAD_CHR_PLUS, `MAD_CHR_PLUS};
    foreach (s[i]) begin
      exp.push_back(s[i]);
    end
    wb(1'b1, `MAD_ADR_CTRL, {30'h0, mst, 1'b1});
    t0 = modem_u.cyc;
    n = 0;
    @(posedge clk_i);
    while (busy === 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    t1 = modem_u.cyc;
    if (busy !== 1'b0) begin
      hang();
    end
    // codes above the start checks are raised after the string went out
    sent = (ee == 4'h0 || ee > 4'h3);
    wb(1'b0, `MAD_ADR_STATUS, 32'h0);
    chk(q[7:0], {ee, 4'h2});
    chk({31'h0, irq}, {31'h0, msk != 2'h0});
    if (rp != 2'h0 && tmo != 16'h0) begin
      wb(1'b0, `MAD_ADR_RSP, 32'h0);
      chk(q, (rp == 2'h1) ? 32'h00004b4f : 32'h00005245);
    end
    wb(1'b0, `MAD_ADR_IRQ_STAT, 32'h0);
    chk(q, {30'h0, ee != 4'h0, 1'b1});
    wb(1'b0, `MAD_ADR_IRQ_STAT, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk(modem_u.got.size(), sent ? exp.size() : 0);
    if (sent && modem_u.got.size() == exp.size()) begin
      foreach (exp[i]) begin
        chk(modem_u.got[i], exp[i]);
      end
      chk(modem_u.when[0] - t0 >= SIL, 1);
      chk(modem_u.when[3] - modem_u.when[2] >= SIL, 1);
      if (!slw) begin
        chk(modem_u.when[3] - modem_u.when[2] <= SIL + 5, 1);
      end
      if (tmo == 16'h0) begin
        chk(t1 - modem_u.when[$] <= 4, 1);
      end
    end
    if (ee == 4'h4 && modem_u.got.size() > 0) begin
      chk(t1 - modem_u.when[$] >= 1000 * CPM * tmo, 1);
      chk(t1 - modem_u.when[$] <= 1000 * CPM * tmo + 4, 1);
    end
    $display("test done: len %0d timeout %0d code %0d", len, tmo, ee);
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    wdat = 32'h0;
    sel = 4'hf;
    slow = 1'b0;
    reply = 2'h0;
    void'($urandom(32'h4b24e41d));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, a hole and the write-only string window read zero
    wb(1'b1, 12'h100, 32'hffffffff);
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, i < 8 ? 12'(4 * i) : (i == 8 ? 12'h100 : `MAD_ADR_STR_BASE),
         32'h0);
      chk(q, 32'h0);
    end
    $display("test done: reset values");
    run("", 1 + $urandom_range(40), `MAD_CMD_DIAL, 1, 0, 0, 3, 0, 0);
    run("", 1, `MAD_CMD_DIAL, 1, 0, 0, 3, 0, 0);
    run("", 250, `MAD_CMD_DIAL, 1, 0, 0, 3, 0, 1);
    run("ATDT2345678\015", 0, `MAD_CMD_DIAL, 1, 1, 1, 3, 0, 0);
    run("ATZ\015", 0, `MAD_CMD_DIAL, 1, 1, 2, 3, 5, 0);
    run("ATZ\015", 0, `MAD_CMD_DIAL, 1, 1, 0, 3, 4, 0);
    run("ATH0\015", 0, `MAD_CMD_DIAL, 1, 0, 0, 0, 0, 0);
    run("", 4, 16'h1ce9, 1, 0, 0, 3, 1, 0);
    run("", 4, `MAD_CMD_DIAL, 0, 0, 0, 3, 2, 0);
    run("", 0, `MAD_CMD_DIAL, 1, 0, 0, 3, 3, 0);
    run("", 251, `MAD_CMD_DIAL, 1, 0, 0, 3, 3, 0);
    close_out();
  end
endmodule
`default_nettype wire
